// >>> dv/cc_flags_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the bus handshake and the formed addresses of the flags core
module cc_flags_chk
  import cc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic irq_request,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_accept,
  input wire logic [15:0] src_address,
  input wire logic [15:0] dst_address,
  input wire logic src_mem_access,
  input wire logic dst_mem_access
);
  logic [15:0] pc_q;
  logic [2:0] sm_q;
  logic [2:0] dm_q;
  logic br_q;
  logic [7:0] sb_q;
  logic [7:0] db_q;
  logic tk;
  logic [15:0] src_rel;
  logic [15:0] dst_rel;
  assign tk = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // branch targets, taken only when the condition bit is set
  assign src_rel = br_q ? pc_q + {{8{sb_q[7]}}, sb_q} : pc_q;
  assign dst_rel = br_q ? pc_q + {{8{db_q[7]}}, db_q} : pc_q;
  // shadow of the address setup, updated on the design's taking edge
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q <= 16'h0000;
      sm_q <= 3'h0;
      dm_q <= 3'h0;
      br_q <= 1'b0;
      sb_q <= 8'h00;
      db_q <= 8'h00;
    end else if (tk && wb_adr_i == ADDR_RESULT) begin
      pc_q <= wb_dat_i[15:0];
      sm_q <= wb_dat_i[18:16];
      dm_q <= wb_dat_i[22:20];
      br_q <= wb_dat_i[24];
    end else if (tk && wb_adr_i == ADDR_OPERANDS) begin
      sb_q <= wb_sel_i[2] ? wb_dat_i[23:16] : sb_q;
      db_q <= wb_sel_i[3] ? wb_dat_i[31:24] : db_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // outputs lag the setup by one edge, so judge only once it settled
  sequence s_settled;
    !$past(tk);
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_fixed_ones;
    s_req ##0 (!wb_we_i && wb_adr_i == ADDR_FLAGS)
      |=> wb_dat_o[6:5] == 2'b11;
  endproperty
  a_fixed_ones: assert property (p_fixed_ones)
    else $error("bits 6:5 low");
  property p_inherent;
    s_settled ##0 sm_q == INHERENT_MODE
      |-> src_address == pc_q && !src_mem_access;
  endproperty
  a_inherent: assert property (p_inherent)
    else $error("inherent fetch");
  property p_immediate;
    s_settled ##0 sm_q == IMMEDIATE_MODE
      |-> src_address == pc_q && src_mem_access;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate addr");
  property p_direct_src;
    s_settled ##0 sm_q == DIRECT_MODE
      |-> src_address == {DIRECT_PAGE_HI, sb_q};
  endproperty
  a_direct_src: assert property (p_direct_src)
    else $error("direct src");
  property p_direct_dst;
    s_settled ##0 dm_q == DIRECT_MODE
      |-> dst_address == {DIRECT_PAGE_HI, db_q};
  endproperty
  a_direct_dst: assert property (p_direct_dst)
    else $error("direct dst");
  property p_rel_src;
    s_settled ##0 sm_q == RELATIVE_MODE |-> src_address == src_rel;
  endproperty
  a_rel_src: assert property (p_rel_src)
    else $error("branch src");
  property p_rel_dst;
    s_settled ##0 dm_q == RELATIVE_MODE |-> dst_address == dst_rel;
  endproperty
  a_rel_dst: assert property (p_rel_dst)
    else $error("branch dst");
  property p_irq_quiet;
    !irq_request [*4] |=> !irq_accept;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("stray accept");
endmodule : cc_flags_chk
bind cc_flags_core cc_flags_chk i_chk (.clk(clk), .reset(reset),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .irq_request(irq_request), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_accept(irq_accept), .src_address(src_address),
  .dst_address(dst_address), .src_mem_access(src_mem_access),
  .dst_mem_access(dst_mem_access));
`default_nettype wire

// >>> dv/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory and register space answering on the operand address
module mem_model (
  input wire logic clk,
  input wire logic [15:0] address,
  input wire logic access,
  output logic [7:0] rdata = 8'h00
);
  // one flat space, every byte derived from its full address
  // unselected, the data line toggles so stale data never looks valid
  always_ff @(posedge clk) begin
    if (access) begin
      rdata <= address[15:8] ^ address[7:0];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : mem_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
// flags and addresses driven over wishbone, checked against hand values
module tb
  import cc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, irq = 1'b0;
  logic [31:0] rdat;
  logic [31:0] x;
  logic ack, acc, sm, dm;
  logic [15:0] sa, da;
  logic [7:0] mdat;
  int fails = 0, comparisons = 0, cycles = 0;
  always #12.5 clk = ~clk;
  cc_flags_core i_dut (.clk(clk), .reset(reset), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .irq_request(irq), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_accept(acc), .src_address(sa), .dst_address(da),
    .src_mem_access(sm), .dst_mem_access(dm));
  mem_model i_mem (.clk(clk), .address(sa), .access(sm), .rdata(mdat));
  task test_done;
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] g, e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // preset flags and operands, run one op, compare masked result and flags
  task automatic t(input alu_op_t c, input logic [7:0] a, b, f0, rm, r,
                   fm, f);
    wb(1'b1, ADDR_FLAGS, {24'h0, f0}, x);
    wb(1'b1, ADDR_OPERANDS, {16'h0, b, a}, x);
    wb(1'b1, ADDR_COMMAND, {28'h0, c}, x);
    wb(1'b0, ADDR_COMMAND, 32'h0, x);
    chk("result", x[7:0] & rm, r);
    wb(1'b0, ADDR_FLAGS, 32'h0, x);
    chk("flags", x[7:0] & fm, f);
  endtask : t
  task automatic ad(input logic [31:0] cfg, input logic [15:0] ops, es,
                    ed, input logic [1:0] am, ea);
    wb(1'b1, ADDR_OPERANDS, {ops, 16'h0}, x);
    wb(1'b1, ADDR_RESULT, cfg, x);
    repeat (3) @(posedge clk);
    chk("src_address", sa, es);
    chk("dst_address", da, ed);
    chk("mem_access", {sm, dm} & am, ea);
  endtask : ad
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, ADDR_FLAGS, 32'h0, x);
    chk("flags_reset", x[7:0], FLAGS_RESET);
    wb(1'b0, 4'h2, 32'h0, x);
    chk("unmapped", x, 32'h0);
    t(OP_ADD, 8'h7f, 8'h01, 8'h00, 8'hff, 8'h80, 8'h97,
      8'h94);
    t(OP_ADD, 8'hff, 8'h01, 8'h00, 8'hff, 8'h00, 8'h97,
      8'h13);
    t(OP_ADC, 8'h0f, 8'h00, 8'h01, 8'hff, 8'h10, 8'h97,
      8'h10);
    // zero minus one borrows but stays inside the signed range
    t(OP_SUB, 8'h00, 8'h01, 8'h00, 8'hff, 8'hff, 8'h87,
      8'h05);
    t(OP_SUB, 8'h80, 8'h01, 8'h00, 8'hff, 8'h7f, 8'h87,
      8'h80);
    t(OP_SBC, 8'h05, 8'h05, 8'h01, 8'hff, 8'hff, 8'h87,
      8'h05);
    t(OP_AND, 8'hf0, 8'h0f, 8'h04, 8'hff, 8'h00, 8'h06,
      8'h02);
    t(OP_LOAD8, 8'h00, 8'h80, 8'h02, 8'hff, 8'h80, 8'h06,
      8'h04);
    // a 16-bit load leaves the byte result of the previous load alone
    t(OP_LOAD16, 8'h00, 8'h80, 8'h02, 8'hff, 8'h80, 8'h06,
      8'h04);
    wb(1'b0, ADDR_COMMAND, 32'h0, x);
    chk("imm_word", x[31:16], 16'h8000);
    t(OP_LOAD16, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h06,
      8'h02);
    t(OP_DECIMAL_ADJUST, 8'h40, 8'h00, 8'h10, 8'hff, 8'h46, 8'h01,
      8'h00);
    t(OP_DECIMAL_ADJUST, 8'h9a, 8'h00, 8'h00, 8'hff, 8'h00, 8'h01,
      8'h01);
    t(OP_SHIFT_LEFT, 8'h81, 8'h00, 8'h00, 8'hff, 8'h02, 8'h01,
      8'h01);
    t(OP_ROTATE_RIGHT, 8'h01, 8'h00, 8'h00, 8'hff, 8'h00, 8'h01,
      8'h01);
    t(OP_BIT_TEST, 8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01,
      8'h01);
    t(OP_BIT_TEST, 8'h10, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01,
      8'h00);
    t(OP_TRANSFER_TO_FLAGS, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'hff,
      8'h60);
    wb(1'b0, ADDR_COMMAND, 32'h0, x);
    chk("transfer_hold", x[8], 1'b1);
    t(OP_SET_MASK, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
      8'h08);
    t(OP_TAKE_INTERRUPT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
      8'h08);
    // mask set: request waits; clear opens it only after one more boundary
    irq <= 1'b1;
    wb(1'b1, ADDR_FLAGS, 32'h08, x);
    repeat (6) @(posedge clk);
    chk("irq_masked", acc, 1'b0);
    wb(1'b1, ADDR_COMMAND, {28'h0, OP_CLEAR_MASK}, x);
    wb(1'b0, ADDR_COMMAND, 32'h0, x);
    chk("mask_hold", x[8], 1'b1);
    repeat (6) @(posedge clk);
    chk("irq_held", acc, 1'b0);
    wb(1'b1, ADDR_COMMAND, {28'h0, OP_NONE}, x);
    repeat (6) @(posedge clk);
    chk("irq_open", acc, 1'b1);
    wb(1'b1, ADDR_COMMAND, {28'h0, OP_TAKE_INTERRUPT}, x);
    repeat (6) @(posedge clk);
    chk("irq_taken", acc, 1'b0);
    irq <= 1'b0;
    ad(32'h0030_1234, 16'h8055, 16'h1234, 16'h0080, 2'b11,
       2'b01);
    ad(32'h0002_2000, 16'h0000, 16'h2000, 16'h2000, 2'b11,
       2'b10);
    ad(32'h0131_1000, 16'hfffe, 16'h0ffe, 16'h00ff, 2'b01,
       2'b01);
    ad(32'h0111_fff0, 16'h107f, 16'h006f, 16'h0000, 2'b00,
       2'b00);
    ad(32'h0011_4000, 16'h107f, 16'h4000, 16'h4000, 2'b01,
       2'b00);
    ad(32'h0023_abcd, 16'h00ff, 16'h00ff, 16'habcd, 2'b11,
       2'b11);
    chk("mem_data", mdat, 8'hff);
    test_done();
  end
endmodule : tb
`default_nettype wire

// >>> src/cc_flags_core.sv
`timescale 1ns/1ps
`default_nettype none
module cc_flags_core
  import cc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic irq_request,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_accept,
  output logic [15:0] src_address,
  output logic [15:0] dst_address,
  output logic src_mem_access,
  output logic dst_mem_access
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] acc_a_reg;
  logic [7:0] acc_b_reg;
  logic [15:0] pc_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [15:0] imm_word_reg;
  logic [7:0] imm_hi_reg;
  logic [7:0] src_byte_reg;
  logic [7:0] dst_byte_reg;
  logic [2:0] src_mode_reg;
  logic [2:0] dst_mode_reg;
  logic branch_cond_reg;
  logic mask_hold_reg;
  logic mask_hold_next;
  logic req_sync1_reg;
  logic req_sync2_reg;
  logic [15:0] src_addr_w;
  logic [15:0] dst_addr_w;
  logic src_mem_w;
  logic dst_mem_w;
  logic bus_req;
  logic wr_cmd;
  alu_op_t op_w;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] bcd_fix;
  logic bcd_carry;
  // largest packed decimal byte; anything above needs the high correction
  localparam logic [7:0] BCD_BYTE_MAX = {BCD_NIBBLE_MAX, BCD_NIBBLE_MAX};

  // tests one byte-lane select bit of wb_sel_i; used by every register write
  function automatic logic lane_hit(input logic [3:0] sel, input int lane);
    lane_hit = sel[lane];
  endfunction : lane_hit

  // fixed bits are forced so software can never clear them
  function automatic logic [7:0] fix_flags(input logic [7:0] f);
    fix_flags = f | FLAGS_FIXED;
  endfunction : fix_flags

  // ack high blocks a second take of the same request cycle
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd = bus_req && wb_we_i && (wb_adr_i == ADDR_COMMAND)
    && lane_hit(wb_sel_i, 0);
  // opcode decoded every cycle; it only acts on a command write
  assign op_w = alu_op_t'(wb_dat_i[3:0]);

  // two-stage sync of the asynchronous interrupt request pin
  always_ff @(posedge clk) begin
    if (reset) begin
      req_sync1_reg <= 1'b0;
      req_sync2_reg <= 1'b0;
    end else begin
      req_sync1_reg <= irq_request;
      req_sync2_reg <= req_sync1_reg;
    end
  end

  // arithmetic and flag computation for the commanded operation
  always_comb begin
    flags_next = flags_reg;
    result_next = result_reg;
    mask_hold_next = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    bcd_fix = 8'h00;
    bcd_carry = 1'b0;
    case (op_w)
      OP_ADD, OP_ADC: begin
        sum9 = {1'b0, acc_a_reg} + {1'b0, acc_b_reg}
          + {8'h00, (op_w == OP_ADC) & flags_reg[FLAG_C]};
        sum5 = {1'b0, acc_a_reg[3:0]} + {1'b0, acc_b_reg[3:0]}
          + {4'h0, (op_w == OP_ADC) & flags_reg[FLAG_C]};
        result_next = sum9[7:0];
        flags_next[FLAG_H] = sum5[4]; // carry from bit 3 to 4
        flags_next[FLAG_C] = sum9[8]; // carry out of bit 7
        flags_next[FLAG_V] = (acc_a_reg[7] == acc_b_reg[7])
          && (sum9[7] != acc_a_reg[7]);
        flags_next[FLAG_N] = sum9[7];
        flags_next[FLAG_Z] = (sum9[7:0] == 8'h00);
      end
      OP_SUB, OP_SBC: begin
        sum9 = {1'b0, acc_a_reg} - {1'b0, acc_b_reg}
          - {8'h00, (op_w == OP_SBC) & flags_reg[FLAG_C]};
        result_next = sum9[7:0];
        flags_next[FLAG_C] = sum9[8]; // borrow needed
        flags_next[FLAG_V] = (acc_a_reg[7] != acc_b_reg[7])
          && (sum9[7] != acc_a_reg[7]);
        flags_next[FLAG_N] = sum9[7];
        flags_next[FLAG_Z] = (sum9[7:0] == 8'h00);
      end
      OP_AND: begin
        result_next = acc_a_reg & acc_b_reg;
        flags_next[FLAG_V] = 1'b0; // logic ops never overflow
        flags_next[FLAG_N] = result_next[7];
        flags_next[FLAG_Z] = (result_next == 8'h00);
      end
      OP_LOAD8: begin
        result_next = acc_b_reg;
        flags_next[FLAG_V] = 1'b0;
        flags_next[FLAG_N] = acc_b_reg[7];
        flags_next[FLAG_Z] = (acc_b_reg == 8'h00);
      end
      OP_LOAD16: begin
        // 16-bit value assembled high byte first
        flags_next[FLAG_V] = 1'b0;
        flags_next[FLAG_N] = imm_word_reg[15];
        flags_next[FLAG_Z] = (imm_word_reg == 16'h0000);
      end
      OP_DECIMAL_ADJUST: begin
        // correction chosen from half-carry, carry and nibble range
        if (flags_reg[FLAG_H] || (acc_a_reg[3:0] > BCD_NIBBLE_MAX)) begin
          bcd_fix = bcd_fix | BCD_LOW_FIX;
        end
        if (flags_reg[FLAG_C] || (acc_a_reg > BCD_BYTE_MAX)) begin
          bcd_fix = bcd_fix | BCD_HIGH_FIX;
          bcd_carry = 1'b1;
        end
        result_next = acc_a_reg + bcd_fix;
        flags_next[FLAG_C] = bcd_carry;
        flags_next[FLAG_N] = result_next[7];
        flags_next[FLAG_Z] = (result_next == 8'h00);
      end
      OP_SHIFT_LEFT: begin
        result_next = {acc_a_reg[6:0], 1'b0};
        flags_next[FLAG_C] = acc_a_reg[7];
        flags_next[FLAG_N] = acc_a_reg[6];
        flags_next[FLAG_Z] = (acc_a_reg[6:0] == 7'h00);
        flags_next[FLAG_V] = acc_a_reg[7] ^ acc_a_reg[6];
      end
      OP_ROTATE_RIGHT: begin
        result_next = {flags_reg[FLAG_C], acc_a_reg[7:1]};
        flags_next[FLAG_C] = acc_a_reg[0];
        flags_next[FLAG_N] = flags_reg[FLAG_C];
        flags_next[FLAG_Z] = ({flags_reg[FLAG_C], acc_a_reg[7:1]} == 8'h00);
        flags_next[FLAG_V] = flags_reg[FLAG_C] ^ acc_a_reg[0];
      end
      OP_BIT_TEST: begin
        // tested bit index from operand b low bits lands in carry
        flags_next[FLAG_C] = acc_a_reg[acc_b_reg[2:0]];
      end
      OP_CLEAR_MASK: begin
        // the hold only matters when the mask was set before
        flags_next[FLAG_I] = 1'b0;
        mask_hold_next = flags_reg[FLAG_I]; // hold one boundary
      end
      OP_SET_MASK: begin
        flags_next[FLAG_I] = 1'b1;
      end
      OP_TRANSFER_TO_FLAGS: begin
        flags_next = acc_a_reg;
        mask_hold_next = flags_reg[FLAG_I] & ~acc_a_reg[FLAG_I];
      end
      OP_TAKE_INTERRUPT: begin
        // issued by the sequencer once stacking is done
        flags_next[FLAG_I] = 1'b1;
      end
      default: begin
        flags_next = flags_reg;
      end
    endcase
    flags_next = fix_flags(flags_next);
  end

  // flag register and one-boundary interrupt hold
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= FLAGS_RESET;
      result_reg <= 8'h00;
      mask_hold_reg <= 1'b0;
    end else if (wr_cmd) begin
      flags_reg <= flags_next;
      result_reg <= result_next;
      mask_hold_reg <= mask_hold_next;
    end else if (bus_req && wb_we_i && (wb_adr_i == ADDR_FLAGS)
        && lane_hit(wb_sel_i, 0)) begin
      flags_reg <= fix_flags(wb_dat_i[7:0]);
    end
  end

  // maskable interrupt gate, registered output
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_accept <= 1'b0;
    end else begin
      irq_accept <= req_sync2_reg && !flags_reg[FLAG_I]
        && !mask_hold_reg;
    end
  end

  // operand, pc and addressing setup registers
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_a_reg <= 8'h00;
      acc_b_reg <= 8'h00;
      pc_reg <= 16'h0000;
      imm_hi_reg <= 8'h00;
      imm_word_reg <= 16'h0000;
      src_byte_reg <= 8'h00;
      dst_byte_reg <= 8'h00;
      src_mode_reg <= 3'h0;
      dst_mode_reg <= 3'h0;
      branch_cond_reg <= 1'b0;
    end else if (bus_req && wb_we_i && (wb_adr_i == ADDR_OPERANDS)) begin
      if (lane_hit(wb_sel_i, 0)) begin
        acc_a_reg <= wb_dat_i[7:0];
      end
      if (lane_hit(wb_sel_i, 1)) begin
        acc_b_reg <= wb_dat_i[15:8];
        // byte after opcode is the high half, next is low
        imm_hi_reg <= wb_dat_i[15:8];
      end
      if (lane_hit(wb_sel_i, 2)) begin
        // a high byte written in the same access wins over the held one
        if (lane_hit(wb_sel_i, 1)) begin
          imm_word_reg <= {wb_dat_i[15:8], wb_dat_i[23:16]};
        end else begin
          imm_word_reg <= {imm_hi_reg, wb_dat_i[23:16]};
        end
        src_byte_reg <= wb_dat_i[23:16];
      end
      if (lane_hit(wb_sel_i, 3)) begin
        dst_byte_reg <= wb_dat_i[31:24];
      end
    end else if (bus_req && wb_we_i && (wb_adr_i == ADDR_RESULT)) begin
      if (lane_hit(wb_sel_i, 0)) begin
        pc_reg[7:0] <= wb_dat_i[7:0];
      end
      if (lane_hit(wb_sel_i, 1)) begin
        pc_reg[15:8] <= wb_dat_i[15:8];
      end
      if (lane_hit(wb_sel_i, 2)) begin
        // two independent mode fields for moves
        src_mode_reg <= wb_dat_i[18:16];
        dst_mode_reg <= wb_dat_i[22:20];
      end
      if (lane_hit(wb_sel_i, 3)) begin
        branch_cond_reg <= wb_dat_i[24];
      end
    end
  end

  // source and destination formed separately
  operand_address u_src_addr (
    .mode(addr_mode_t'(src_mode_reg)),
    .pc(pc_reg),
    .operand_byte(src_byte_reg),
    .take_branch(branch_cond_reg),
    .address(src_addr_w),
    .mem_access(src_mem_w)
  );

  // destination former shares pc and branch condition with the source
  operand_address u_dst_addr (
    .mode(addr_mode_t'(dst_mode_reg)),
    .pc(pc_reg),
    .operand_byte(dst_byte_reg),
    .take_branch(branch_cond_reg),
    .address(dst_addr_w),
    .mem_access(dst_mem_w)
  );

  // registered address outputs onto the 16-bit bus
  always_ff @(posedge clk) begin
    if (reset) begin
      src_address <= 16'h0000;
      dst_address <= 16'h0000;
      src_mem_access <= 1'b0;
      dst_mem_access <= 1'b0;
    end else begin
      src_address <= src_addr_w;
      dst_address <= dst_addr_w;
      src_mem_access <= src_mem_w;
      dst_mem_access <= dst_mem_w;
    end
  end

  // wishbone slave: one wait state, ack for any address, unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      // read data is captured at the taking edge and stands until next read
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_FLAGS: wb_dat_o <= {24'h000000, flags_reg};
          ADDR_OPERANDS: wb_dat_o <= {dst_byte_reg, src_byte_reg,
            acc_b_reg, acc_a_reg};
          ADDR_COMMAND: wb_dat_o <= {imm_word_reg, 7'h00,
            mask_hold_reg, result_reg};
          ADDR_RESULT: wb_dat_o <= {7'h00, branch_cond_reg, 1'b0,
            dst_mode_reg, 1'b0, src_mode_reg, pc_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : cc_flags_core
`default_nettype wire

// >>> src/cc_pkg.sv
package cc_pkg;
  // condition_flags bit positions
  localparam int FLAG_V = 7;
  localparam int FLAG_ONE_HI = 6;
  localparam int FLAG_ONE_LO = 5;
  localparam int FLAG_H = 4;
  localparam int FLAG_I = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  // bits 6 and 5 are fixed high; mask set out of reset
  localparam logic [7:0] FLAGS_FIXED = 8'h60;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_NIBBLE_MAX = 4'h9;

  // wishbone register offsets (byte addresses)
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_OPERANDS = 4'h4;
  localparam logic [3:0] ADDR_COMMAND = 4'h8;
  localparam logic [3:0] ADDR_RESULT = 4'hc;

  // operation codes written to the command register
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_ADC = 4'h2,
    OP_SUB = 4'h3,
    OP_SBC = 4'h4,
    OP_AND = 4'h5,
    OP_LOAD8 = 4'h6,
    OP_LOAD16 = 4'h7,
    OP_DECIMAL_ADJUST = 4'h8,
    OP_SHIFT_LEFT = 4'h9,
    OP_ROTATE_RIGHT = 4'ha,
    OP_BIT_TEST = 4'hb,
    OP_CLEAR_MASK = 4'hc,
    OP_SET_MASK = 4'hd,
    OP_TRANSFER_TO_FLAGS = 4'he,
    OP_TAKE_INTERRUPT = 4'hf
  } alu_op_t;

  // addressing modes for address formation
  typedef enum logic [2:0] {
    INHERENT_MODE = 3'h0,
    RELATIVE_MODE = 3'h1,
    IMMEDIATE_MODE = 3'h2,
    DIRECT_MODE = 3'h3
  } addr_mode_t;
endpackage : cc_pkg

// >>> src/operand_address.sv
`timescale 1ns/1ps
`default_nettype none
// combinational operand and branch address former
module operand_address
  import cc_pkg::*;
(
  input wire addr_mode_t mode,
  input wire logic [15:0] pc,
  input wire logic [7:0] operand_byte,
  input wire logic take_branch,
  output logic [15:0] address,
  output logic mem_access
);
  always_comb begin
    address = pc;
    mem_access = 1'b0;
    case (mode)
      INHERENT_MODE: begin
        address = pc; // operands live in cpu registers
        mem_access = 1'b0;
      end
      RELATIVE_MODE: begin
        // sign-extend and add only when the branch holds
        if (take_branch) begin
          address = pc + {{8{operand_byte[7]}}, operand_byte};
        end else begin
          address = pc;
        end
      end
      IMMEDIATE_MODE: begin
        address = pc; // operand byte sits right after opcode
        mem_access = 1'b1;
      end
      DIRECT_MODE: begin
        address = {DIRECT_PAGE_HI, operand_byte};
        mem_access = 1'b1;
      end
      default: begin
        address = pc;
        mem_access = 1'b0;
      end
    endcase
  end
endmodule : operand_address
`default_nettype wire
